// ### hdl/pmrs_pkg.sv
// package of constants and types for the power-mode and reset sequencer
// Behaviour
// - idle bit write enters idle after instruction
// - idle gates only the core clock
// - idle freezes core state and port pins
// - enabled interrupt ends idle, clears idle bit
// - release select chooses service routine or resume
// - reset pin low eight clocks is valid
// - any reset zeroes pc, restores registers
// - watchdog runs in idle, interrupt wakes
// - watchdog reset 512 clocks after timeout flag
// - watchdog reset held two machine cycles
// - software restart prevents timeout for interval
// - power-down bit write stops all clocks
// - reset pin wakes power-down after warm-up
// - watchdog inactive in power-down
// - enabled external or ring wakes after warm-up
// - after wake routine, resume next instruction
// - rc select runs rc until crystal warm
// - reset pin sampled at state four, synchronous
// - reset extends up to two cycles past release
// - three reset sources, two with cause flags
// - external reset sets no cause flag
package pmrs_pkg;
    // register word offsets
    localparam logic [3:0] PMRS_ADDR_PCTL   = 4'h0;
    localparam logic [3:0] PMRS_ADDR_PMODE  = 4'h1;
    localparam logic [3:0] PMRS_ADDR_WDCTL  = 4'h2;
    localparam logic [3:0] PMRS_ADDR_IRQEN  = 4'h3;
    localparam logic [3:0] PMRS_ADDR_STATUS = 4'h4;
    // power control fields
    localparam int PMRS_PCTL_IDLE    = 0;
    localparam int PMRS_PCTL_PDOWN   = 1;
    localparam int PMRS_PCTL_RELSEL  = 4;
    // power mode fields
    localparam int PMRS_PMODE_RCSEL  = 5;
    // watchdog control fields
    localparam int PMRS_WD_RESTART   = 0;
    localparam int PMRS_WD_RSTEN     = 1;
    localparam int PMRS_WD_IRQEN     = 2;
    localparam int PMRS_WD_FLAG      = 3;
    localparam int PMRS_WD_PORF      = 6;
    localparam int PMRS_WD_WDRF      = 7;
    // irq enable fields
    localparam int PMRS_EN_EXT0      = 0;
    localparam int PMRS_EN_EXT1      = 1;
    localparam int PMRS_EN_RING      = 2;
    localparam int PMRS_EN_GLOBAL    = 7;
    // timing
    localparam int PMRS_STATES_PER_MC  = 4;
    localparam logic [1:0] PMRS_SAMPLE_STATE = 2'h3; // state four of the cycle
    localparam int PMRS_RST_MIN_CLK    = 8;
    localparam int PMRS_RST_MIN_SMP    = PMRS_RST_MIN_CLK / PMRS_STATES_PER_MC;
    localparam int PMRS_WD_GRACE_CLK   = 512;
    localparam int PMRS_HOLD_MC        = 2;
    localparam int PMRS_HOLD_CLK       = PMRS_HOLD_MC * PMRS_STATES_PER_MC;
    localparam int PMRS_WARMUP_CLK     = 65536;
    localparam int PMRS_WD_INTERVAL    = 131072;
    localparam logic [7:0] PMRS_RST_VAL = 8'h00;

    typedef enum logic [2:0] {
        PMRS_NORMAL = 3'b000,
        PMRS_IDLE   = 3'b001,
        PMRS_PDOWN  = 3'b011,
        PMRS_WARM   = 3'b010,
        PMRS_RESET  = 3'b110
    } pmrs_state_t;

    // clock gate outputs travel together
    typedef struct packed {
        logic core_clk_en;
        logic periph_clk_en;
        logic osc_en;
        logic rc_osc_sel;
    } pmrs_clk_t;
endpackage

// ### hdl/pmrs_top.sv
// power-mode and reset sequencer with classic wishbone register slave
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
module pmrs_top #(
    parameter int WARMUP_CLK  = pmrs_pkg::PMRS_WARMUP_CLK,
    parameter int WD_INTERVAL = pmrs_pkg::PMRS_WD_INTERVAL
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              por_i,
    input  wire logic              reset_n_i,
    input  wire logic              ext0_n_i,
    input  wire logic              ext1_n_i,
    input  wire logic              ring_i,
    input  wire logic              irq_pending_i,
    input  wire logic              insn_done_i,
    input  wire logic              reti_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [3:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    output pmrs_pkg::pmrs_clk_t    clk_ctl_o,
    output logic                   cpu_rst_o,
    output logic                   hold_ports_o,
    output logic                   wake_irq_o,
    output logic                   wd_irq_o
);
    localparam int WB = $clog2(WARMUP_CLK + 1);
    localparam int DB = $clog2(WD_INTERVAL + 1);
    localparam int GB = 10;
    localparam int HB = 4;
    localparam logic [GB-1:0] GRACE = GB'(pmrs_pkg::PMRS_WD_GRACE_CLK);
    localparam logic [HB-1:0] HOLD  = HB'(pmrs_pkg::PMRS_HOLD_CLK);

    pmrs_pkg::pmrs_state_t state_reg, state_next;
    logic [1:0]     phase_reg;
    logic [1:0]     low_cnt_reg;
    logic           pin_rst_reg;
    logic [HB-1:0]  hold_reg;
    logic [WB-1:0]  warm_reg;
    logic [DB-1:0]  wd_reg;
    logic [GB-1:0]  grace_reg;
    logic           grace_run_reg;
    logic           wake_rst_reg;
    logic [7:0]     pctl_reg;
    logic [7:0]     pmode_reg;
    logic [7:0]     wdctl_reg;
    logic [7:0]     irqen_reg;
    logic           rc_run_reg;
    logic           post_pd_reg;

    // bus decode
    wire bus_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr     = bus_req & wb_we_i & wb_sel_i[0];
    wire wr_pctl    = bus_wr & (wb_adr_i == pmrs_pkg::PMRS_ADDR_PCTL);
    wire wr_pmode   = bus_wr & (wb_adr_i == pmrs_pkg::PMRS_ADDR_PMODE);
    wire wr_wdctl   = bus_wr & (wb_adr_i == pmrs_pkg::PMRS_ADDR_WDCTL);
    wire wr_irqen   = bus_wr & (wb_adr_i == pmrs_pkg::PMRS_ADDR_IRQEN);
    wire wd_restart = wr_wdctl & wb_dat_i[pmrs_pkg::PMRS_WD_RESTART];

    // reset pin sampling and source detection
    wire sample_now = (phase_reg == pmrs_pkg::PMRS_SAMPLE_STATE);
    wire pin_valid  = 32'(low_cnt_reg) >= pmrs_pkg::PMRS_RST_MIN_SMP;
    wire wd_fire    = grace_run_reg & (grace_reg == GRACE - GB'(1));
    wire in_pd      = (state_reg == pmrs_pkg::PMRS_PDOWN);
    wire in_idle    = (state_reg == pmrs_pkg::PMRS_IDLE);
    wire in_warm    = (state_reg == pmrs_pkg::PMRS_WARM);
    wire gen_en     = irqen_reg[pmrs_pkg::PMRS_EN_GLOBAL];
    wire pd_wake    = gen_en & ((~ext0_n_i & irqen_reg[pmrs_pkg::PMRS_EN_EXT0])
                    | (~ext1_n_i & irqen_reg[pmrs_pkg::PMRS_EN_EXT1])
                    | (ring_i & irqen_reg[pmrs_pkg::PMRS_EN_RING]));
    wire wd_flag    = wdctl_reg[pmrs_pkg::PMRS_WD_FLAG];
    wire wd_irq     = wd_flag & wdctl_reg[pmrs_pkg::PMRS_WD_IRQEN] & gen_en;
    wire idle_wake  = irq_pending_i | wd_irq;
    // a pin held low past power-down waits for the warm-up before taking effect
    wire any_rst    = por_i | (pin_valid & ~in_pd & ~in_warm) | wd_fire;
    wire wd_tick    = ~in_pd & (state_reg != pmrs_pkg::PMRS_WARM);
    wire wd_over    = wd_tick & (32'(wd_reg) == WD_INTERVAL - 1);
    wire warm_done  = 32'(warm_reg) == WARMUP_CLK - 1;

    // mode sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            pmrs_pkg::PMRS_NORMAL: begin
                if (insn_done_i & pctl_reg[pmrs_pkg::PMRS_PCTL_PDOWN])
                    state_next = pmrs_pkg::PMRS_PDOWN;
                else if (insn_done_i & pctl_reg[pmrs_pkg::PMRS_PCTL_IDLE])
                    state_next = pmrs_pkg::PMRS_IDLE;
            end
            pmrs_pkg::PMRS_IDLE: begin
                if (idle_wake)
                    state_next = pmrs_pkg::PMRS_NORMAL;
            end
            pmrs_pkg::PMRS_PDOWN: begin
                if (pin_valid | pd_wake)
                    state_next = pmrs_pkg::PMRS_WARM;
            end
            pmrs_pkg::PMRS_WARM: begin
                if (warm_done)
                    state_next = wake_rst_reg ? pmrs_pkg::PMRS_RESET
                                              : pmrs_pkg::PMRS_NORMAL;
            end
            pmrs_pkg::PMRS_RESET: begin
                if (hold_reg == HOLD - HB'(1) && !(~reset_n_i))
                    state_next = pmrs_pkg::PMRS_NORMAL;
            end
            default: state_next = pmrs_pkg::PMRS_RESET;
        endcase
        if (any_rst)
            state_next = pmrs_pkg::PMRS_RESET;
    end

    // state, phase and reset pin filter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg   <= pmrs_pkg::PMRS_RESET;
            phase_reg   <= 2'h0;
            low_cnt_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            phase_reg <= phase_reg + 2'h1;
            if (in_pd)
                low_cnt_reg <= reset_n_i ? 2'h0 : 2'h2;
            else if (reset_n_i)
                low_cnt_reg <= 2'h0;
            else if (sample_now && !pin_valid)
                low_cnt_reg <= low_cnt_reg + 2'h1;
        end
    end

    // reset hold counter and warm-up counter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_reg     <= '0;
            warm_reg     <= '0;
            wake_rst_reg <= 1'b0;
        end else begin
            if (state_reg != pmrs_pkg::PMRS_RESET || any_rst || ~reset_n_i)
                hold_reg <= '0;
            else if (hold_reg != HOLD - HB'(1))
                hold_reg <= hold_reg + HB'(1);
            if (state_reg == pmrs_pkg::PMRS_WARM)
                warm_reg <= warm_reg + WB'(1);
            else
                warm_reg <= '0;
            if (in_pd)
                wake_rst_reg <= pin_valid;
        end
    end

    // watchdog counter and grace timer
    always_ff @(posedge clk_i) begin
        if (rst_i || cpu_rst_o) begin
            wd_reg        <= '0;
            grace_reg     <= '0;
            grace_run_reg <= 1'b0;
        end else begin
            if (wd_restart) begin
                wd_reg        <= '0;
                grace_reg     <= '0;
                grace_run_reg <= 1'b0;
            end else if (wd_tick) begin
                wd_reg <= wd_over ? '0 : wd_reg + DB'(1);
                if (wd_flag & wdctl_reg[pmrs_pkg::PMRS_WD_RSTEN] & ~grace_run_reg)
                    grace_run_reg <= 1'b1;
                if (grace_run_reg)
                    grace_reg <= grace_reg + GB'(1);
            end
        end
    end

    // software registers with hardware set and clear; one process owns the whole
    // watchdog byte, so the cause flags are kept apart from the cpu reset by branch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pctl_reg  <= pmrs_pkg::PMRS_RST_VAL;
            pmode_reg <= pmrs_pkg::PMRS_RST_VAL;
            irqen_reg <= pmrs_pkg::PMRS_RST_VAL;
            wdctl_reg <= pmrs_pkg::PMRS_RST_VAL;
        end else begin
            if (cpu_rst_o) begin
                pctl_reg       <= pmrs_pkg::PMRS_RST_VAL;
                pmode_reg      <= pmrs_pkg::PMRS_RST_VAL;
                irqen_reg      <= pmrs_pkg::PMRS_RST_VAL;
                wdctl_reg[5:0] <= 6'h00;
            end else begin
                if (wr_pctl)
                    pctl_reg <= wb_dat_i[7:0];
                if (in_idle & idle_wake)
                    pctl_reg[pmrs_pkg::PMRS_PCTL_IDLE] <= 1'b0;
                if (state_reg == pmrs_pkg::PMRS_WARM && warm_done)
                    pctl_reg[pmrs_pkg::PMRS_PCTL_PDOWN] <= 1'b0;
                if (wr_pmode)
                    pmode_reg <= wb_dat_i[7:0];
                if (wr_irqen)
                    irqen_reg <= wb_dat_i[7:0];
                if (wr_wdctl)
                    wdctl_reg[5:0] <= {wb_dat_i[5:4], wb_dat_i[3] & wd_flag,
                                       wb_dat_i[2:1], 1'b0};
                if (wd_over & ~wd_restart)
                    wdctl_reg[pmrs_pkg::PMRS_WD_FLAG] <= 1'b1;                     // set wins
            end
            // cause flags, cleared only by rst_i or software
            if (por_i)
                wdctl_reg[pmrs_pkg::PMRS_WD_PORF] <= 1'b1;
            else if (wr_wdctl & ~wb_dat_i[pmrs_pkg::PMRS_WD_PORF])
                wdctl_reg[pmrs_pkg::PMRS_WD_PORF] <= 1'b0;
            if (wd_fire)
                wdctl_reg[pmrs_pkg::PMRS_WD_WDRF] <= 1'b1;
            else if (wr_wdctl & ~wb_dat_i[pmrs_pkg::PMRS_WD_WDRF])
                wdctl_reg[pmrs_pkg::PMRS_WD_WDRF] <= 1'b0;
        end
    end

    // rc oscillator selection on power-down exit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rc_run_reg  <= 1'b0;
            post_pd_reg <= 1'b0;
        end else begin
            if (in_pd & (pin_valid | pd_wake))
                rc_run_reg <= pmode_reg[pmrs_pkg::PMRS_PMODE_RCSEL];
            else if (state_reg == pmrs_pkg::PMRS_WARM && warm_done)
                rc_run_reg <= 1'b0;
            if (state_reg == pmrs_pkg::PMRS_WARM && warm_done && !wake_rst_reg)
                post_pd_reg <= 1'b1;
            else if (reti_i | cpu_rst_o)
                post_pd_reg <= 1'b0;
        end
    end

    // read mux
    logic [7:0] rd_byte;
    wire [7:0] status_byte = {3'h0, post_pd_reg, rc_run_reg, state_reg};
    always_comb begin
        case (wb_adr_i)
            pmrs_pkg::PMRS_ADDR_PCTL:   rd_byte = pctl_reg;
            pmrs_pkg::PMRS_ADDR_PMODE:  rd_byte = pmode_reg;
            pmrs_pkg::PMRS_ADDR_WDCTL:  rd_byte = wdctl_reg;
            pmrs_pkg::PMRS_ADDR_IRQEN:  rd_byte = irqen_reg;
            pmrs_pkg::PMRS_ADDR_STATUS: rd_byte = status_byte;
            default:                    rd_byte = 8'h00;
        endcase
    end

    // bus answer and outputs
    wire warm_exit = (state_next == pmrs_pkg::PMRS_NORMAL) && (state_reg == pmrs_pkg::PMRS_WARM);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o     <= 1'b0;
            wb_dat_o     <= 32'h00000000;
            clk_ctl_o    <= '0;
            cpu_rst_o    <= 1'b1;
            hold_ports_o <= 1'b0;
            wake_irq_o   <= 1'b0;
            wd_irq_o     <= 1'b0;
        end else begin
            wb_ack_o  <= bus_req;
            wb_dat_o  <= bus_req ? {24'h000000, rd_byte} : 32'h00000000;
            clk_ctl_o.core_clk_en   <= (state_next == pmrs_pkg::PMRS_NORMAL)
                                     | (state_next == pmrs_pkg::PMRS_RESET);
            clk_ctl_o.periph_clk_en <= (state_next != pmrs_pkg::PMRS_PDOWN)
                                     & (state_next != pmrs_pkg::PMRS_WARM);
            clk_ctl_o.osc_en        <= (state_next != pmrs_pkg::PMRS_PDOWN);
            clk_ctl_o.rc_osc_sel    <= (in_pd & (pin_valid | pd_wake))
                                     ? pmode_reg[pmrs_pkg::PMRS_PMODE_RCSEL]
                                     : rc_run_reg & ~warm_done;
            cpu_rst_o    <= (state_next == pmrs_pkg::PMRS_RESET);
            hold_ports_o <= (state_next == pmrs_pkg::PMRS_IDLE);
            wake_irq_o   <= (in_idle & idle_wake & ~pctl_reg[pmrs_pkg::PMRS_PCTL_RELSEL])
                          | warm_exit;
            wd_irq_o     <= wd_irq;
        end
    end
endmodule

// ### test/pmrs_sva.sv
// assertions on the ports of the power-mode and reset sequencer
`timescale 1ns/1ps
module pmrs_sva #(
    parameter int WARMUP_CLK  = 16,
    parameter int WD_INTERVAL = 64
) (
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic                por_i,
    input wire logic                reset_n_i,
    input wire logic                irq_pending_i,
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_ack_o,
    input wire pmrs_pkg::pmrs_clk_t clk_ctl_o,
    input wire logic                cpu_rst_o,
    input wire logic                hold_ports_o,
    input wire logic                wake_irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    int warm_cnt;
    // counts cycles spent warming up with the core stopped
    always_ff @(posedge clk_i) begin
        if (rst_i || !clk_ctl_o.osc_en || clk_ctl_o.core_clk_en || hold_ports_o || cpu_rst_o)
            warm_cnt <= 0;
        else
            warm_cnt <= warm_cnt + 1;
    end
    a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer late or long");
    a_idle_gating: assert property (hold_ports_o |-> !clk_ctl_o.core_clk_en && clk_ctl_o.periph_clk_en)
        else $error("idle gating wrong");
    a_idle_wake: assert property (hold_ports_o && irq_pending_i |-> ##[1:4] !hold_ports_o)
        else $error("idle not ended by interrupt");
    a_wake_pulse: assert property (wake_irq_o |=> !wake_irq_o)
        else $error("wake request longer than a cycle");
    a_pin_reset: assert property ((!reset_n_i && clk_ctl_o.periph_clk_en) [*8] |-> ##[0:3] cpu_rst_o)
        else $error("held reset pin not taken");
    a_reset_follows: assert property (!reset_n_i && cpu_rst_o |=> cpu_rst_o)
        else $error("reset left while pin low");
    a_reset_min: assert property ($fell(cpu_rst_o) |-> $past(cpu_rst_o, 8))
        else $error("internal reset too short");
    a_release_bound: assert property ($rose(reset_n_i) && cpu_rst_o |-> ##[1:9] !cpu_rst_o)
        else $error("reset kept too long after release");
    a_pdown_stop: assert property (!clk_ctl_o.osc_en |-> !clk_ctl_o.core_clk_en && !clk_ctl_o.periph_clk_en)
        else $error("clock running with oscillator off");
    a_no_pd_reset: assert property ($rose(cpu_rst_o) && !por_i && !$past(por_i) |-> $past(clk_ctl_o.osc_en))
        else $error("reset raised in power-down");
    a_warm_bound: assert property (warm_cnt <= WARMUP_CLK + 4)
        else $error("warm-up too long");
    // main scenarios reached
    c_idle_wake: cover property (hold_ports_o && irq_pending_i);
    c_wake_req: cover property (wake_irq_o);
    c_reset: cover property ($rose(cpu_rst_o));
    c_warm: cover property (warm_cnt == WARMUP_CLK);
endmodule
bind pmrs_top pmrs_sva #(.WARMUP_CLK(WARMUP_CLK), .WD_INTERVAL(WD_INTERVAL)) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .reset_n_i(reset_n_i),
    .irq_pending_i(irq_pending_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .clk_ctl_o(clk_ctl_o), .cpu_rst_o(cpu_rst_o),
    .hold_ports_o(hold_ports_o), .wake_irq_o(wake_irq_o));

// ### test/pmrs_far.sv
// model of the reset source and wake pins outside the sequencer
`timescale 1ns/1ps
module pmrs_far (
    input  wire logic clk_i,
    output logic      reset_n_o,
    output logic      ext0_n_o,
    output logic      ext1_n_o,
    output logic      ring_o
);
    // released pins rest at their pulled levels
    initial begin
        reset_n_o = 1'b1;
        ext0_n_o  = 1'b1;
        ext1_n_o  = 1'b1;
        ring_o    = 1'b0;
    end
    // holds the reset pin low for n clocks, called at an edge
    task automatic rst_low(input int n);
        reset_n_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        reset_n_o <= 1'b1;
    endtask
    // holds one wake source active for n clocks
    task automatic wake(input int src, input int n);
        ext0_n_o <= src != 0;
        ext1_n_o <= src != 1;
        ring_o   <= src == 2;
        repeat (n) @(posedge clk_i);
        ext0_n_o <= 1'b1;
        ext1_n_o <= 1'b1;
        ring_o   <= 1'b0;
    endtask
endmodule

// ### test/test_pmrs_top.sv
// self-checking bench for the power-mode and reset sequencer
`timescale 1ns/1ps
module test_pmrs_top;
    logic clk_i = 0, rst_i = 1, por_i = 0, irq_i = 0, insn_i = 0, reti_i = 0;
    logic cyc = 0, stb = 0, we = 0, ack, cpu_rst, hold, wake, wdirq, rstn, e0n, e1n, ring;
    logic seen_wake = 0, seen_rst = 0, seen_rc = 0;
    logic [3:0]  adr = 4'h0, sel = 4'h1;
    logic [31:0] wdat = 32'h0, rdat;
    logic [7:0]  q, d;
    pmrs_pkg::pmrs_clk_t ctl;
    int n_fail = 0, compares = 0, i, j;
    always #5 clk_i = ~clk_i;
    pmrs_far far (.clk_i(clk_i), .reset_n_o(rstn), .ext0_n_o(e0n), .ext1_n_o(e1n), .ring_o(ring));
    pmrs_top #(.WARMUP_CLK(16), .WD_INTERVAL(64)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .reset_n_i(rstn), .ext0_n_i(e0n),
        .ext1_n_i(e1n), .ring_i(ring), .irq_pending_i(irq_i), .insn_done_i(insn_i),
        .reti_i(reti_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .clk_ctl_o(ctl),
        .cpu_rst_o(cpu_rst), .hold_ports_o(hold), .wake_irq_o(wake), .wd_irq_o(wdirq));
    // sticky record of short pulses
    always @(posedge clk_i) begin
        if (wake) seen_wake <= 1;
        if (cpu_rst) seen_rst <= 1;
        if (ctl.rc_osc_sel) seen_rc <= 1;
    end
    task automatic results;
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one classic bus cycle, read byte left in q
    task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] v);
        int k;
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, v};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = rdat[7:0];
        if (ack !== 1'b1) begin
            n_fail++;
            results();
        end
        cyc <= 0;
        stb <= 0;
        @(posedge clk_i);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic done;
        insn_i <= 1;
        tick(1);
        insn_i <= 0;
    endtask
    task automatic wait_st(input logic [2:0] st);
        for (i = 0; i < 80; i++) begin
            wb(4'h4, 0, 8'h00);
            if (q[2:0] === st) break;
        end
        chk("state", q[2:0], st);
        if (i == 80) results();
    endtask
    task automatic wait_hi(ref logic s, input int lim, input string nm);
        for (int k = 0; k < lim && s !== 1'b1; k++)
            @(posedge clk_i);
        chk(nm, s, 1);
        if (s !== 1'b1) results();
    endtask
    // readback of a written control byte: mode and enable bytes are stored whole
    function automatic logic [7:0] rb(input logic [3:0] a, input logic [7:0] v);
        return (a == 4'h1 || a == 4'h3) ? v : 8'h00;
    endfunction
    // main sequence
    initial begin
        void'($urandom(32'hE5949C2F));
        tick(5);
        rst_i <= 0;
        tick(4);
        chk("rst hold", cpu_rst, 1);
        wait_st(3'h0);
        for (j = 0; j < 4; j++) begin
            wb(j[3:0], 0, 8'h00);
            chk("reset value", q & 8'h3F, 8'h00);
        end
        for (j = 0; j < 6; j++) begin
            d = 8'($urandom);
            wb(j[0] ? 4'h3 : 4'h1, 1, d);
            wb(j[0] ? 4'h3 : 4'h1, 0, 8'h00);
            chk("readback", q, rb(j[0] ? 4'h3 : 4'h1, d));
        end
        wb(4'hF, 1, 8'hFF);
        wb(4'hF, 0, 8'h00);
        chk("unmapped", q, 8'h00);
        // a write without byte lane zero is ignored
        wb(4'h1, 1, 8'h00);
        sel <= 4'hE;
        wb(4'h1, 1, 8'hFF);
        sel <= 4'h1;
        wb(4'h1, 0, 8'h00);
        chk("lane", q, 8'h00);
        wb(4'h4, 1, 8'hFF);
        wait_st(3'h0);
        for (j = 0; j < 2; j++) begin
            wb(4'h0, 1, j ? 8'h11 : 8'h01);
            done();
            wait_st(3'h1);
            chk("gates", {ctl, hold}, 5'b01101);
            seen_wake = 0;
            irq_i <= 1;
            wait_st(3'h0);
            irq_i <= 0;
            chk("wake", seen_wake, j == 0);
            wb(4'h0, 0, 8'h00);
            chk("idle bit", q[0], 0);
        end
        seen_rst = 0;
        far.rst_low(4);
        tick(12);
        chk("short pin", seen_rst, 0);
        wb(4'h0, 1, 8'h01);
        done();
        wait_st(3'h1);
        far.rst_low(8);
        wait_st(3'h0);
        chk("pin reset", seen_rst, 1);
        wb(4'h2, 0, 8'h00);
        chk("causes", q & 8'hC0, 8'h00);
        wb(4'h3, 1, 8'h07);
        wb(4'h0, 1, 8'h02);
        done();
        wait_st(3'h3);
        chk("stopped", ctl, 4'h0);
        far.wake(0, 8);
        tick(30);
        wb(4'h4, 0, 8'h00);
        chk("no wake", q[2:0], 3'h3);
        seen_rst = 0;
        far.rst_low(4);
        wait_st(3'h2);
        wait_st(3'h0);
        chk("pd reset", seen_rst, 1);
        wb(4'h0, 0, 8'h00);
        chk("pd cleared", q, 8'h00);
        for (j = 0; j < 3; j++) begin
            wb(4'h1, 1, j == 2 ? 8'h20 : 8'h00);
            wb(4'h3, 1, 8'h80 | (8'h01 << j));
            wb(4'h0, 1, 8'h02);
            done();
            wait_st(3'h3);
            seen_wake = 0;
            seen_rc = 0;
            far.wake(j, 4 + $urandom % 8);
            wait_st(3'h0);
            chk("pd wake", {seen_wake, seen_rc}, {1'b1, j == 2});
            wb(4'h0, 0, 8'h00);
            chk("pd bit", q, 8'h00);
            wb(4'h4, 0, 8'h00);
            chk("resume set", q[4], 1);
            reti_i <= 1;
            tick(1);
            reti_i <= 0;
            wb(4'h4, 0, 8'h00);
            chk("resume done", q[4], 0);
        end
        wb(4'h3, 1, 8'h80);
        for (j = 0; j < 4; j++) begin
            wb(4'h2, 1, 8'h05);
            tick(40);
        end
        chk("restarted", wdirq, 0);
        wb(4'h0, 1, 8'h11);
        done();
        wait_st(3'h1);
        wait_hi(wdirq, 100, "wd irq");
        wait_st(3'h0);
        seen_rst = 0;
        wb(4'h2, 1, 8'h03);
        tick(500);
        chk("wd early", seen_rst, 0);
        wait_hi(seen_rst, 300, "wd reset");
        wait_st(3'h0);
        wb(4'h2, 0, 8'h00);
        chk("wd cause", q & 8'hC0, 8'h80);
        por_i <= 1;
        tick(2);
        por_i <= 0;
        wait_st(3'h0);
        wb(4'h2, 0, 8'h00);
        chk("por cause", q[6], 1);
        results();
    end
endmodule
